/* logic/tbcs_bank.sv */
// Configuration register bank of a switch port in transparent mode,
// seen by software as a type 1 bridge header, over an AHB-Lite slave.
// Assumes one master, whole-word single transfers, and a cold reset
// that only power-on asserts while reset_n follows hot resets.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "tbcs_regs.svh"
module tbcs_bank
    import tbcs_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5678, // Arbitrary value
    parameter logic [7:0]  REVISION    = 8'h01     // Arbitrary value
) (
    // Clock and resets
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             cold_reset_n,
    // Register bus
    input  wire tbcs_ahb_req_type ahb_req,
    output tbcs_ahb_rsp_type      ahb_rsp,
    // Hardware events that set status bits
    input  wire logic [15:0]      prim_status_set,
    input  wire logic [15:0]      sec_status_set,
    input  wire logic [31:0]      core_error_set,
    // Hardware-initialized values
    input  wire logic [31:0]      hw_init_phy,
    // Block state
    output logic                  init_done,
    output logic [15:0]           bridge_command,
    output logic [15:0]           bridge_control,
    output logic [1:0]            power_state
);

    // ============================================================
    // Bus slave: capture address phase, write in data phase
    tbcs_state_type state_q;
    logic [7:0]     waddr_q;
    logic           wr_en;
    logic [31:0]    wd;
    logic           take;
    logic           rd_take;
    logic [31:0]    rdata_q;
    logic [31:0]    rd_mux;
    logic           rd_retry_q;
    logic [7:0]     raddr_q;
    logic [7:0]     rd_addr;

    assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    assign wd   = ahb_req.hwdata;

    // Wait states are inserted until init is done, so no access
    // sees an unloaded hardware-initialized field, and once in the
    // data phase of a read whose address phase met the data phase of a write
    assign ahb_rsp.hreadyout = init_done && !rd_retry_q;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = rdata_q;

    // Address phase capture
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= TBCS_IDLE;
            waddr_q <= 8'h00;
        end else if (take && ahb_req.hwrite) begin
            state_q <= TBCS_WDATA;
            waddr_q <= {ahb_req.haddr[7:2], 2'b00};
        end else if (ahb_rsp.hreadyout) begin
            state_q <= TBCS_IDLE;
        end
    end

    assign wr_en   = (state_q == TBCS_WDATA) && init_done;
    assign rd_take = take && !ahb_req.hwrite;

    // Read after write: a read whose address phase meets the data
    // phase of a write would capture the word before the write lands.
    // One wait state costs little against a stale read of a status
    // bit that software has just cleared.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_retry_q <= 1'b0;
            raddr_q    <= 8'h00;
        end else begin
            rd_retry_q <= rd_take && wr_en;
            if (rd_take) begin
                raddr_q <= {ahb_req.haddr[7:2], 2'b00};
            end
        end
    end

    // The retry cycle reads the held address, not the bus
    assign rd_addr = rd_retry_q ? raddr_q : {ahb_req.haddr[7:2], 2'b00};

    // Hardware-initialized load one cycle after release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
        end
    end

    // ============================================================
    // Plain read-write registers, restored by every reset
    logic [15:0] cmd_q;
    logic [15:0] bctl_q;
    logic [7:0]  int_line_q;
    logic [15:0] cache_lat_q;
    logic [31:0] bus_q;
    logic [15:0] io_q;
    logic [31:0] mem_q;
    logic [31:0] pref_q;
    logic [31:0] pbu_q;
    logic [31:0] plu_q;
    logic [31:0] iou_q;
    logic [15:0] msi_ctl_q;
    logic [31:0] msi_addr_q;
    logic [31:0] msi_uaddr_q;
    logic [15:0] msi_data_q;
    logic [1:0]  pm_q;
    logic [31:0] ack_q;
    logic [31:0] phy0_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q       <= 16'h0000;
            bctl_q      <= 16'h0000;
            int_line_q  <= 8'h00;
            cache_lat_q <= 16'h0000;
            bus_q       <= `TBCS_RST_ZERO;
            io_q        <= 16'h0000;
            mem_q       <= `TBCS_RST_ZERO;
            pref_q      <= `TBCS_RST_ZERO;
            pbu_q       <= `TBCS_RST_ZERO;
            plu_q       <= `TBCS_RST_ZERO;
            iou_q       <= `TBCS_RST_ZERO;
            msi_ctl_q   <= 16'h0000;
            msi_addr_q  <= `TBCS_RST_ZERO;
            msi_uaddr_q <= `TBCS_RST_ZERO;
            msi_data_q  <= 16'h0000;
            pm_q        <= 2'b00;
            ack_q       <= `TBCS_RST_ACK_REPLAY;
        end else if (wr_en) begin
            unique case (waddr_q)
                `TBCS_OFF_STATUS_CMD:
                    cmd_q <= wd[15:0] & `TBCS_CMD_RW_MASK;
                `TBCS_OFF_HDR_TYPE:   cache_lat_q <= wd[15:0];
                `TBCS_OFF_BUS_NUM:    bus_q <= wd;
                `TBCS_OFF_SEC_STAT_IO: io_q <= wd[15:0];
                `TBCS_OFF_MEM_WIN:    mem_q <= wd;
                `TBCS_OFF_PREF_WIN:   pref_q <= wd;
                `TBCS_OFF_PREF_BASE_UP: pbu_q <= wd;
                `TBCS_OFF_PREF_LIM_UP:  plu_q <= wd;
                `TBCS_OFF_IO_UP:      iou_q <= wd;
                `TBCS_OFF_BRIDGE_CTL: begin
                    int_line_q <= wd[7:0];
                    bctl_q     <= wd[31:16] & `TBCS_BCTL_RW_MASK;
                end
                `TBCS_OFF_PM_CSR:
                    pm_q <= wd[1:0];
                `TBCS_OFF_MSI_CTL:
                    msi_ctl_q <= wd[31:16] & `TBCS_MSI_CTL_RW_MASK;
                `TBCS_OFF_MSI_ADDR:   msi_addr_q <= {wd[31:2], 2'b00};
                `TBCS_OFF_MSI_UADDR:  msi_uaddr_q <= wd;
                `TBCS_OFF_MSI_DATA:   msi_data_q <= wd[15:0];
                `TBCS_OFF_ACK_REPLAY: ack_q <= wd;
                default: ;
            endcase
        end
    end

    // Hardware-initialized field, reloaded after each reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phy0_q <= `TBCS_RST_ZERO;
        end else if (!init_done) begin
            phy0_q <= hw_init_phy;
        end else if (wr_en && waddr_q == `TBCS_OFF_PHY0) begin
            phy0_q <= wd;
        end
    end

    // ============================================================
    // Write-one-clear status bits; a set in the clear cycle wins
    logic [15:0] pstat_q;
    logic [15:0] sstat_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pstat_q <= 16'h0000;
            sstat_q <= 16'h0000;
        end else begin
            pstat_q <= (pstat_q & ~((wr_en &&
                        waddr_q == `TBCS_OFF_STATUS_CMD) ?
                        wd[31:16] : 16'h0000)) |
                       (prim_status_set & `TBCS_STAT_W1C_MASK);
            sstat_q <= (sstat_q & ~((wr_en &&
                        waddr_q == `TBCS_OFF_SEC_STAT_IO) ?
                        wd[31:16] : 16'h0000)) |
                       (sec_status_set & `TBCS_SEC_W1C_MASK);
        end
    end

    // ============================================================
    // Sticky registers: only cold reset restores them, the hot
    // reset leaves them alone so error history survives link resets
    logic [31:0] csr_err_q;  // Sticky write-one-clear
    logic [31:0] csr_ros_q;  // Sticky read-only, last error seen
    logic [31:0] sticky_rw_q [0:4];
    logic [7:0]  sticky_off  [0:4];

    assign sticky_off[0] = `TBCS_OFF_CSR0;
    assign sticky_off[1] = `TBCS_OFF_PHY1;
    assign sticky_off[2] = `TBCS_OFF_CSR4;
    assign sticky_off[3] = `TBCS_OFF_CSR67_TL;
    assign sticky_off[4] = `TBCS_OFF_PHY3;

    always_ff @(posedge mclk or negedge cold_reset_n) begin
        if (!cold_reset_n) begin
            csr_err_q <= `TBCS_RST_ZERO;
            csr_ros_q <= `TBCS_RST_ZERO;
        end else begin
            csr_err_q <= (csr_err_q & ~((wr_en &&
                          waddr_q == `TBCS_OFF_CSR1) ?
                          wd : 32'h0000_0000)) |
                         core_error_set;
            if (|core_error_set) begin
                csr_ros_q <= core_error_set;
            end
        end
    end

    // Sticky read-write words, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sticky
            always_ff @(posedge mclk or negedge cold_reset_n) begin
                if (!cold_reset_n) begin
                    sticky_rw_q[gi] <= `TBCS_RST_ZERO;
                end else if (wr_en && waddr_q == sticky_off[gi]) begin
                    sticky_rw_q[gi] <= wd;
                end
            end
        end
    endgenerate

    // ============================================================
    // Read mux: type 1 header at standard offsets
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (rd_addr)
            `TBCS_OFF_IDENTITY:    rd_mux = {DEVICE_CODE, VENDOR_CODE};
            `TBCS_OFF_STATUS_CMD:  rd_mux = {pstat_q, cmd_q};
            `TBCS_OFF_CLASS_REV:
                rd_mux = {`TBCS_CLASS_BRIDGE, REVISION};
            `TBCS_OFF_HDR_TYPE:
                rd_mux = {8'h00, `TBCS_HDR_TYPE1, cache_lat_q};
            `TBCS_OFF_BUS_NUM:     rd_mux = bus_q;
            `TBCS_OFF_SEC_STAT_IO: rd_mux = {sstat_q, io_q};
            `TBCS_OFF_MEM_WIN:     rd_mux = mem_q;
            `TBCS_OFF_PREF_WIN:    rd_mux = pref_q;
            `TBCS_OFF_PREF_BASE_UP: rd_mux = pbu_q;
            `TBCS_OFF_PREF_LIM_UP: rd_mux = plu_q;
            `TBCS_OFF_IO_UP:       rd_mux = iou_q;
            `TBCS_OFF_CAP_PTR:
                rd_mux = {24'h000000, `TBCS_CAP_PTR_VAL};
            `TBCS_OFF_BRIDGE_CTL:
                rd_mux = {bctl_q, `TBCS_RST_INT_PIN, int_line_q};
            `TBCS_OFF_PM_CAP:      rd_mux = `TBCS_PM_CAP_VAL;
            `TBCS_OFF_PM_CSR:      rd_mux = {30'h0, pm_q};
            `TBCS_OFF_MSI_CTL:     rd_mux = {msi_ctl_q, `TBCS_MSI_CAP_HDR};
            `TBCS_OFF_MSI_ADDR:    rd_mux = msi_addr_q;
            `TBCS_OFF_MSI_UADDR:   rd_mux = msi_uaddr_q;
            `TBCS_OFF_MSI_DATA:    rd_mux = {16'h0000, msi_data_q};
            `TBCS_OFF_VND_CAP:     rd_mux = `TBCS_VND_CAP_VAL;
            `TBCS_OFF_CSR0:        rd_mux = sticky_rw_q[0];
            `TBCS_OFF_CSR1:        rd_mux = csr_err_q;
            `TBCS_OFF_ACK_REPLAY:  rd_mux = ack_q;
            `TBCS_OFF_PHY0:        rd_mux = phy0_q;
            `TBCS_OFF_PHY1:        rd_mux = sticky_rw_q[1];
            `TBCS_OFF_CSR4:        rd_mux = sticky_rw_q[2];
            `TBCS_OFF_CSR5:        rd_mux = csr_ros_q;
            `TBCS_OFF_CSR67_TL:    rd_mux = sticky_rw_q[3];
            `TBCS_OFF_PHY3:        rd_mux = sticky_rw_q[4];
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase edge, and again at
    // the end of a retry cycle once the colliding write has landed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_take || rd_retry_q) begin
            rdata_q <= rd_mux;
        end
    end

    // ============================================================
    // Block state outputs
    assign bridge_command = cmd_q;
    assign bridge_control = bctl_q;
    assign power_state    = pm_q & 2'(`TBCS_PM_STATE_MASK);

endmodule : tbcs_bank

/* logic/tbcs_regs.svh */
// Constants of the bridge configuration register bank: offsets, fields,
// reset values and header identity values.
// Assumes inclusion by the package and the bank module only.
//
// Contract
// - Transparent port appears as type 1 bridge.
// - Header laid out at standard type 1 offsets.
// - Capability pointer at 34h reads 40h.
// - Write-one-clear bits clear on 1, keep on 0.
// - Sticky clear and read-only bits survive hot resets.
// - Sticky read-write bits survive ordinary resets.
`ifndef TBCS_REGS_SVH
`define TBCS_REGS_SVH

// ============================================================
// Register offsets (byte addresses)
`define TBCS_OFF_IDENTITY      8'h00
`define TBCS_OFF_STATUS_CMD    8'h04
`define TBCS_OFF_CLASS_REV     8'h08
`define TBCS_OFF_HDR_TYPE      8'h0c
`define TBCS_OFF_BUS_NUM       8'h18
`define TBCS_OFF_SEC_STAT_IO   8'h1c
`define TBCS_OFF_MEM_WIN       8'h20
`define TBCS_OFF_PREF_WIN      8'h24
`define TBCS_OFF_PREF_BASE_UP  8'h28
`define TBCS_OFF_PREF_LIM_UP   8'h2c
`define TBCS_OFF_IO_UP         8'h30
`define TBCS_OFF_CAP_PTR       8'h34
`define TBCS_OFF_BRIDGE_CTL    8'h3c
`define TBCS_OFF_PM_CAP        8'h40
`define TBCS_OFF_PM_CSR        8'h44
`define TBCS_OFF_MSI_CTL       8'h4c
`define TBCS_OFF_MSI_ADDR      8'h50
`define TBCS_OFF_MSI_UADDR     8'h54
`define TBCS_OFF_MSI_DATA      8'h58
`define TBCS_OFF_VND_CAP       8'h64
`define TBCS_OFF_CSR0          8'h68
`define TBCS_OFF_CSR1          8'h6c
`define TBCS_OFF_ACK_REPLAY    8'h70
`define TBCS_OFF_PHY0          8'h74
`define TBCS_OFF_PHY1          8'h78
`define TBCS_OFF_CSR4          8'h84
`define TBCS_OFF_CSR5          8'h88
`define TBCS_OFF_CSR67_TL      8'h8c
`define TBCS_OFF_PHY3          8'h90

// ============================================================
// Fixed read values of the header and capability chain
`define TBCS_HDR_TYPE1         8'h01
`define TBCS_CAP_PTR_VAL       8'h40
`define TBCS_PM_CAP_VAL        32'h0003_4c01
`define TBCS_MSI_CAP_HDR       16'h6405
`define TBCS_VND_CAP_VAL       32'h0034_b009
`define TBCS_CLASS_BRIDGE      24'h060400

// ============================================================
// Field positions of write-one-clear status bits and writable fields
`define TBCS_STAT_W1C_MASK     16'hf900
`define TBCS_SEC_W1C_MASK      16'hf900
`define TBCS_PM_STATE_MASK     32'h0000_0003
`define TBCS_CMD_RW_MASK       16'h0547
`define TBCS_BCTL_RW_MASK      16'h0fff
`define TBCS_MSI_CTL_RW_MASK   16'h0071

// ============================================================
// Reset values
`define TBCS_RST_ZERO          32'h0000_0000
`define TBCS_RST_ACK_REPLAY    32'h0000_0000
`define TBCS_RST_INT_PIN       8'h01

`endif

/* logic/tbcs_pkg.sv */
// Types shared by the bridge configuration register bank.
// Assumes the constants header is on the include path.
package tbcs_pkg;
    `include "tbcs_regs.svh"

    // ============================================================
    // AHB-Lite slave request and answer
    typedef struct packed {
        logic        hsel;
        logic [7:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } tbcs_ahb_req_type;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } tbcs_ahb_rsp_type;

    // Bus slave states
    typedef enum logic [1:0] {
        TBCS_IDLE  = 2'b01,
        TBCS_WDATA = 2'b10
    } tbcs_state_type;
endpackage : tbcs_pkg

/* verif/tbcs_bank_properties.sv */
// Checker of the bridge configuration bank, watching its ports only.
// Assumes one clock domain; a hot reset disables every check.
`timescale 1ns/1ps
module tbcs_bank_properties
    import tbcs_pkg::*;
(
    // Clock and reset
    input wire logic             mclk,
    input wire logic             reset_n,
    // Register bus
    input wire tbcs_ahb_req_type ahb_req,
    input wire tbcs_ahb_rsp_type ahb_rsp,
    // Events and block state
    input wire logic [15:0]      prim_status_set,
    input wire logic             init_done,
    input wire logic [15:0]      bridge_command,
    input wire logic [15:0]      bridge_control
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ============================================================
    // Transfer steps
    wire take_w = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
    sequence rd_s(logic [7:0] a);
        take_w && !ahb_req.hwrite && ahb_req.haddr == a;
    endsequence
    sequence wr_s(logic [7:0] a);
        take_w && ahb_req.hwrite && ahb_req.haddr == a;
    endsequence
    // Status write of all ones, no event, read-back a little later
    sequence clr_s;
        wr_s(8'h04) ##1 (ahb_req.hwdata[31:16] == 16'hffff) ##0
        ((prim_status_set == 16'h0) throughout (##[2:4] rd_s(8'h04)));
    endsequence
    property rd_p(logic [7:0] a, logic [31:0] m, logic [31:0] v);
        rd_s(a) |=> (ahb_rsp.hrdata & m) == v;
    endproperty
    // ============================================================
    // Assertions
    hdr_type_a: assert property (rd_p(8'h0c, 32'hff_0000, 32'h1_0000))
        else $error("header type is not type 1");
    class_code_a: assert property (rd_p(8'h08, ~32'hff, 32'h0604_0000))
        else $error("class code is not a bridge");
    unmapped_zero_a: assert property (rd_p(8'h10, '1, 32'h0))
        else $error("reserved offset reads nonzero");
    cap_ptr_a: assert property (rd_p(8'h34, '1, 32'h40))
        else $error("capability pointer wrong");
    pm_chain_a: assert property (rd_p(8'h40, 32'hffff, 32'h4c01))
        else $error("first capability header wrong");
    status_clear_a: assert property (clr_s |=>
        (ahb_rsp.hrdata[31:16] & 16'hf900) == 16'h0)
        else $error("status bits survived a clear");
    cmd_update_a: assert property (wr_s(8'h04) ##1 1'b1 |=>
        bridge_command == (16'h0547 & $past(ahb_req.hwdata[15:0])))
        else $error("command output wrong after write");
    bctl_update_a: assert property (wr_s(8'h3c) ##1 1'b1 |=>
        bridge_control == (16'h0fff & $past(ahb_req.hwdata[31:16])))
        else $error("bridge control output wrong after write");
    init_first_a: assert property (take_w |=> init_done)
        else $error("access taken before initialisation");
    okay_resp_a: assert property (ahb_rsp.hresp == 1'b0)
        else $error("response is not OKAY");
endmodule : tbcs_bank_properties

bind tbcs_bank tbcs_bank_properties chk_u (
    .mclk            (mclk),
    .reset_n         (reset_n),
    .ahb_req         (ahb_req),
    .ahb_rsp         (ahb_rsp),
    .prim_status_set (prim_status_set),
    .init_done       (init_done),
    .bridge_command  (bridge_command),
    .bridge_control  (bridge_control)
);

/* verif/tbcs_host.sv */
// Host model: AHB-Lite master doing single whole-word config accesses.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module tbcs_host
    import tbcs_pkg::*;
(
    // Clock
    input  wire logic             mclk,
    // Register bus
    output tbcs_ahb_req_type      ahb_req,
    input  wire tbcs_ahb_rsp_type ahb_rsp
);
    logic        sel_q   = 1'b0;
    logic [7:0]  addr_q  = 8'h0;
    logic [1:0]  trans_q = 2'b00;
    logic        wr_q    = 1'b0;
    logic [31:0] wdata_q = 32'h0;
    // Word size; hready is taken from the one slave
    assign ahb_req = {sel_q, addr_q, trans_q, wr_q, 3'h2,
                      ahb_rsp.hreadyout, wdata_q};
    // One transfer; idle address and write data show inverted values, not stale ones
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        sel_q   <= 1'b1;
        addr_q  <= a;
        trans_q <= 2'b10;
        wr_q    <= w;
        @(posedge mclk);
        while (ahb_rsp.hreadyout !== 1'b1) @(posedge mclk);
        sel_q   <= 1'b0;
        trans_q <= 2'b00;
        addr_q  <= ~a;
        wdata_q <= d;
        @(posedge mclk);
        while (ahb_rsp.hreadyout !== 1'b1) @(posedge mclk);
        q = ahb_rsp.hrdata;
        wdata_q <= ~d;
    endtask : xfer
endmodule : tbcs_host

/* verif/tbcs_bank_tb.sv */
// Bench: header values, access kinds and stickiness across resets.
// Assumes the host model and the checker bind are compiled with it.
`timescale 1ns/1ps
module tbcs_bank_tb
    import tbcs_pkg::*;
;
    logic             mclk         = 1'b0;
    logic             reset_n      = 1'b0;
    logic             cold_reset_n = 1'b0;
    logic [15:0]      prim_set     = 16'h0;
    logic [15:0]      sec_set      = 16'h0;
    logic [31:0]      core_set     = 32'h0;
    logic [31:0]      phy_init     = 32'h0000_3c5a;
    tbcs_ahb_req_type ahb_req;
    tbcs_ahb_rsp_type ahb_rsp;
    logic             init_done;
    logic [15:0]      cmd;
    logic [15:0]      bctl;
    logic [1:0]       pstate;
    int               fail_count   = 0;
    int               n_checks     = 0;
    int               cyc          = 0;
    // 125 MHz clock
    always #4 mclk = ~mclk;
    tbcs_bank dut_u (.mclk(mclk), .reset_n(reset_n),
        .cold_reset_n(cold_reset_n), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
        .prim_status_set(prim_set), .sec_status_set(sec_set),
        .core_error_set(core_set), .hw_init_phy(phy_init),
        .init_done(init_done), .bridge_command(cmd),
        .bridge_control(bctl), .power_state(pstate));
    tbcs_host host_u (.mclk(mclk), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp));
    // ============================================================
    // Shared tasks
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rc(logic [7:0] a, logic [31:0] m, e, string nm);
        logic [31:0] q;
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(nm, q & m, e);
    endtask : rc
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        host_u.xfer(1'b1, a, d, q);
    endtask : wr
    // Hot reset leaves cold_reset_n high; ready one edge after release
    task automatic rst(logic cold);
        @(posedge mclk);
        reset_n      <= 1'b0;
        cold_reset_n <= ~cold;
        repeat (5) @(posedge mclk);
        reset_n      <= 1'b1;
        cold_reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : rst
    // ============================================================
    // Scenarios
    task automatic t_header;
        rc(8'h00, '1, 32'h5678_1234, "identity");
        rc(8'h08, '1, 32'h0604_0001, "class");
        rc(8'h0c, 32'hff_0000, 32'h1_0000, "header type");
        rc(8'h34, '1, 32'h40, "cap pointer");
        rc(8'h40, 32'hffff, 32'h4c01, "pm cap");
        rc(8'h4c, 32'hffff, 32'h6405, "msg cap");
        rc(8'h64, '1, 32'h0034_b009, "vendor cap");
        rc(8'h74, '1, phy_init, "hw init");
        rc(8'h10, '1, 32'h0, "reserved");
        $display("header test done");
    endtask : t_header
    task automatic t_access;
        wr(8'h18, 32'h00aa_5501);
        rc(8'h18, '1, 32'h00aa_5501, "bus numbers");
        wr(8'h34, '1);
        wr(8'h00, '1);
        rc(8'h34, '1, 32'h40, "pointer ro");
        rc(8'h00, '1, 32'h5678_1234, "identity ro");
        wr(8'h04, 32'h0000_ffff);
        #1 chk("command", cmd, 32'h0547);
        wr(8'h3c, '1);
        #1 chk("bridge ctl", bctl, 32'h0fff);
        rc(8'h3c, ~32'hff, 32'h0fff_0100, "int pin");
        wr(8'h44, 32'h3);
        #1 chk("power state", pstate, 32'h3);
        $display("access test done");
    endtask : t_access
    task automatic t_w1c;
        @(posedge mclk) prim_set <= 16'hf900;
        @(posedge mclk) prim_set <= 16'h0;
        rc(8'h04, 32'hf900_0000, 32'hf900_0000, "status set");
        wr(8'h04, 32'h0800_0000);
        rc(8'h04, 32'hf900_0000, 32'hf100_0000, "clear one");
        wr(8'h04, 32'h0);
        rc(8'h04, 32'hf900_0000, 32'hf100_0000, "keep zero");
        wr(8'h04, 32'hffff_0000);
        rc(8'h04, 32'hf900_0000, 32'h0, "clear all");
        @(posedge mclk) sec_set <= 16'h8000;
        @(posedge mclk) sec_set <= 16'h0;
        rc(8'h1c, 32'hf900_0000, 32'h8000_0000, "sec set");
        wr(8'h1c, 32'h8000_0000);
        rc(8'h1c, 32'hf900_0000, 32'h0, "sec clear");
        $display("clear test done");
    endtask : t_w1c
    task automatic t_sticky;
        wr(8'h90, 32'h5a5a_a5a5);
        @(posedge mclk) core_set <= 32'h11;
        @(posedge mclk) core_set <= 32'h0;
        wr(8'h88, '1);
        rc(8'h88, '1, 32'h11, "latched error");
        rc(8'h6c, '1, 32'h11, "sticky w1c set");
        wr(8'h6c, 32'h1);
        rc(8'h6c, '1, 32'h10, "sticky w1c clear");
        rst(1'b0);
        rc(8'h90, '1, 32'h5a5a_a5a5, "sticky rw hot");
        rc(8'h88, '1, 32'h11, "sticky ro hot");
        rc(8'h6c, '1, 32'h10, "sticky w1c hot");
        rc(8'h74, '1, phy_init, "hw init hot");
        rc(8'h18, '1, 32'h0, "plain rw hot");
        rst(1'b1);
        rc(8'h90, '1, 32'h0, "sticky rw cold");
        rc(8'h88, '1, 32'h0, "sticky ro cold");
        rc(8'h6c, '1, 32'h0, "sticky w1c cold");
        $display("sticky test done");
    endtask : t_sticky
    // ============================================================
    // Verdict, hang guard and main sequence
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // Whole run needs fewer than two hundred cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        rst(1'b1);
        t_header();
        t_access();
        t_w1c();
        t_sticky();
        close_out();
    end
endmodule : tbcs_bank_tb
